// ==== src/bpw_defs.svh ====
// register indices, field positions and reset values of the pointer window
`ifndef BPW_DEFS_SVH
`define BPW_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define BPW_IDX_SPAN      8'h54
`define BPW_IDX_SNAP      8'h55
`define BPW_IDX_CLEAR     8'h59
`define BPW_IDX_RD_LO     8'h5A
`define BPW_IDX_RD_HI     8'h5B
`define BPW_IDX_WR_LO     8'h5C
`define BPW_IDX_WR_HI     8'h5D
`define BPW_IDX_STATUS    8'h60

// status register field positions
`define BPW_ST_FROZEN     0
`define BPW_ST_DMA        1
`define BPW_ST_SPAN_OK    2

// reset values
`define BPW_SPAN_RESET    8'hFF
`define BPW_PTR_RESET     16'h0000

`endif

// ==== src/bpw_pkg.sv ====
// types shared by the pointer window and its hold stage
package bpw_pkg;
	// hold stage states, gray coded along track -> armed -> frozen
	typedef enum logic [1:0] {
		HOLD_TRACK  = 2'b00,
		HOLD_ARMED  = 2'b01,
		HOLD_FROZEN = 2'b11
	} hold_state_t;

	// read and write address pointers travelling together
	typedef struct packed {
		logic [15:0] rd;
		logic [15:0] wr;
	} ptr_pair_t;
endpackage

// ==== src/buffer_pointer_window.sv ====
// buffer span masking, stop compare and pointer snapshot behind apb
`timescale 1ns/1ps
`include "bpw_defs.svh"

// Functional notes
// - span byte is low-order ones, doubling span
// - compare pointers to stop inside span only
// - snapshot write during dma freezes pointer copies
// - copies steady; pointer byte read releases hold
// - clear write zeroes read, write, stop pointers
module buffer_pointer_window (
	// clock, reset and clock enable
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        CE,
	// apb register port
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// live pointers from the pointer generator
	input  wire logic [15:0] RD_PTR,
	input  wire logic [15:0] WR_PTR,
	input  wire logic [15:0] STOP_PTR,
	// dma cycle in progress, asynchronous pin
	input  wire logic        DMA_ACTIVE,
	// compare results and pointer control
	output logic [15:0]      SPAN_MASK,
	output logic             RD_AT_STOP,
	output logic             WR_AT_STOP,
	output logic             PTR_CLEAR
);
	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// word index of a byte address, zero for anything unaligned or
	// out of the window (index zero is never mapped)
	function automatic logic [7:0] word_index(input logic [11:0] a);
		word_index = (a[1:0] == 2'b00 && a[11:10] == 2'b00) ?
			a[9:2] : 8'h00;
	endfunction

	// a legal span is a run of ones from bit 0 upward
	function automatic logic span_legal(input logic [7:0] s);
		span_legal = ((s & (s + 8'h01)) == 8'h00);
	endfunction

	// ------------------------------------------------------------
	// dma pin synchroniser
	// ------------------------------------------------------------
	logic dma_s1;
	logic dma_s2;
	logic dma_s3;
	logic dma_q;
	logic next_dma_q;

	// the level only moves once stages two and three agree
	always_comb begin
		next_dma_q = (dma_s2 == dma_s3) ? dma_s3 : dma_q;
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			dma_s1 <= 1'b0;
			dma_s2 <= 1'b0;
			dma_s3 <= 1'b0;
			dma_q  <= 1'b0;
		end else if (CE) begin
			dma_s1 <= DMA_ACTIVE;
			dma_s2 <= dma_s1;
			dma_s3 <= dma_s2;
			dma_q  <= next_dma_q;
		end
	end

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic [7:0]         idx;
	logic               first;
	logic               done;
	logic               wr_done;
	logic               mapped;
	logic [7:0]         span_sel;
	logic [7:0]         next_span;
	logic [31:0]        next_prdata;
	logic               next_pready;
	logic               next_pslverr;
	logic               snap_arm;
	logic               ptr_read;
	logic               next_clear;
	logic               frozen;
	bpw_pkg::ptr_pair_t live;
	bpw_pkg::ptr_pair_t held;

	// one wait state: pready rises in the second access cycle, so
	// read data is prepared a cycle ahead of the completing edge
	assign idx     = word_index(PADDR);
	assign first   = PSEL && PENABLE && !PREADY;
	assign done    = PSEL && PENABLE && PREADY;
	assign wr_done = done && PWRITE && PSTRB[0];
	assign live    = '{rd: RD_PTR, wr: WR_PTR};

	// effects of a completed transfer
	assign snap_arm = wr_done && idx == `BPW_IDX_SNAP;
	assign ptr_read = done && !PWRITE && (idx == `BPW_IDX_RD_LO ||
		idx == `BPW_IDX_RD_HI || idx == `BPW_IDX_WR_LO ||
		idx == `BPW_IDX_WR_HI);

	// register map: which indices answer
	always_comb begin
		unique case (idx)
			`BPW_IDX_SPAN, `BPW_IDX_SNAP, `BPW_IDX_CLEAR,
			`BPW_IDX_RD_LO, `BPW_IDX_RD_HI, `BPW_IDX_WR_LO,
			`BPW_IDX_WR_HI, `BPW_IDX_STATUS: mapped = 1'b1;
			default:                         mapped = 1'b0;
		endcase
	end

	// next bus answer and register values
	always_comb begin
		next_pready  = first;
		next_pslverr = first && !mapped;
		next_prdata  = 32'h0000_0000;
		next_span    = span_sel;
		next_clear   = wr_done && idx == `BPW_IDX_CLEAR;
		if (first && !PWRITE) begin
			// readout comes from the held copies, never the live
			// pointers, but the first pointer byte read releases the hold, so a byte pair can tear during dma
			unique case (idx)
				`BPW_IDX_RD_LO: next_prdata[7:0] = held.rd[7:0];
				`BPW_IDX_RD_HI: next_prdata[7:0] = held.rd[15:8];
				`BPW_IDX_WR_LO: next_prdata[7:0] = held.wr[7:0];
				`BPW_IDX_WR_HI: next_prdata[7:0] = held.wr[15:8];
				`BPW_IDX_STATUS: begin
					next_prdata[`BPW_ST_FROZEN]  = frozen;
					next_prdata[`BPW_ST_DMA]     = dma_q;
					next_prdata[`BPW_ST_SPAN_OK] = span_legal(span_sel);
				end
				default: next_prdata = 32'h0000_0000;
			endcase
		end
		if (wr_done && idx == `BPW_IDX_SPAN) begin
			next_span = PWDATA[7:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			PREADY    <= 1'b0;
			PSLVERR   <= 1'b0;
			PRDATA    <= 32'h0000_0000;
			span_sel  <= `BPW_SPAN_RESET;
			PTR_CLEAR <= 1'b0;
		end else if (CE) begin
			PREADY    <= next_pready;
			PSLVERR   <= next_pslverr;
			PRDATA    <= next_prdata;
			span_sel  <= next_span;
			PTR_CLEAR <= next_clear;
		end
	end

	// ------------------------------------------------------------
	// span mask and stop compare
	// ------------------------------------------------------------
	logic [15:0] next_mask;
	logic        next_rd_stop;
	logic        next_wr_stop;

	// an illegal span pattern still masks bit for bit; the result
	// is unsupported and flagged in the status register
	always_comb begin
		next_mask    = {span_sel, 8'hFF};
		next_rd_stop = ((RD_PTR ^ STOP_PTR) & SPAN_MASK) == 16'h0000;
		next_wr_stop = ((WR_PTR ^ STOP_PTR) & SPAN_MASK) == 16'h0000;
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			SPAN_MASK  <= {`BPW_SPAN_RESET, 8'hFF};
			RD_AT_STOP <= 1'b0;
			WR_AT_STOP <= 1'b0;
		end else if (CE) begin
			SPAN_MASK  <= next_mask;
			RD_AT_STOP <= next_rd_stop;
			WR_AT_STOP <= next_wr_stop;
		end
	end

	// ------------------------------------------------------------
	// snapshot hold stage
	// ------------------------------------------------------------
	ptr_hold u_hold (
		.clk        (CLK),
		.reset      (RESET),
		.ce         (CE),
		.arm        (snap_arm),
		.dma        (dma_q),
		.release_rd (ptr_read),
		.live       (live),
		.held       (held),
		.frozen     (frozen)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_span_mask;
		@(posedge CLK) disable iff (RESET)
		CE |=> SPAN_MASK[15:8] == $past(span_sel) &&
			SPAN_MASK[7:0] == 8'hFF;
	endproperty
	a_span_mask: assert property (p_span_mask)
		else $error("span mask does not follow span setting");

	property p_rd_compare;
		@(posedge CLK) disable iff (RESET)
		CE |=> RD_AT_STOP == ((($past(RD_PTR) ^ $past(STOP_PTR)) &
			$past(SPAN_MASK)) == 16'h0000);
	endproperty
	a_rd_compare: assert property (p_rd_compare)
		else $error("read pointer stop compare wrong");

	property p_wr_low_byte;
		@(posedge CLK) disable iff (RESET)
		CE && SPAN_MASK == 16'h00FF && WR_PTR[7:0] == STOP_PTR[7:0]
		|=> WR_AT_STOP;
	endproperty
	a_wr_low_byte: assert property (p_wr_low_byte)
		else $error("smallest span did not mask the upper byte");

	property p_release;
		@(posedge CLK) disable iff (RESET)
		CE && frozen && ptr_read |=> !frozen;
	endproperty
	a_release: assert property (p_release)
		else $error("pointer byte read did not release the hold");

	property p_clear;
		@(posedge CLK) disable iff (RESET)
		CE && wr_done && idx == `BPW_IDX_CLEAR |=> PTR_CLEAR;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear write gave no pointer clear pulse");

	property p_answer;
		@(posedge CLK) disable iff (RESET)
		CE && first |=> PREADY;
	endproperty
	a_answer: assert property (p_answer)
		else $error("apb access not answered after one wait state");

	c_freeze:  cover property (@(posedge CLK) snap_arm && dma_q);
	c_release: cover property (@(posedge CLK) frozen && ptr_read);
	c_clear:   cover property (@(posedge CLK) PTR_CLEAR);
	c_err:     cover property (@(posedge CLK) PREADY && PSLVERR);
endmodule

// ==== src/ptr_hold.sv ====
// hold stage that freezes copies of the read and write address pointers
`timescale 1ns/1ps
module ptr_hold (
	// clock and control
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              ce,
	// snapshot request, dma level and readout release
	input  wire logic              arm,
	input  wire logic              dma,
	input  wire logic              release_rd,
	// live and held pointers
	input  wire bpw_pkg::ptr_pair_t live,
	output bpw_pkg::ptr_pair_t     held,
	output logic                   frozen
);
	bpw_pkg::hold_state_t state;
	bpw_pkg::hold_state_t next_state;
	bpw_pkg::ptr_pair_t   next_held;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// the armed stage adds one buffer clock so the request is taken
	// on a clean edge before the copies stop following
	always_comb begin
		next_state = state;
		next_held  = held;
		unique case (state)
			bpw_pkg::HOLD_TRACK: begin
				next_held = live;
				if (arm && dma) begin
					next_state = bpw_pkg::HOLD_ARMED;
				end
			end
			bpw_pkg::HOLD_ARMED: begin
				next_held  = live;
				next_state = bpw_pkg::HOLD_FROZEN;
			end
			bpw_pkg::HOLD_FROZEN: begin
				if (release_rd) begin
					next_state = bpw_pkg::HOLD_TRACK;
				end
			end
			default: begin
				next_state = bpw_pkg::HOLD_TRACK;
			end
		endcase
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge clk) begin
		if (reset) begin
			state  <= bpw_pkg::HOLD_TRACK;
			held   <= '0;
			frozen <= 1'b0;
		end else if (ce) begin
			state  <= next_state;
			held   <= next_held;
			frozen <= (next_state == bpw_pkg::HOLD_FROZEN);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_frozen_stable;
		@(posedge clk) disable iff (reset)
		frozen |=> $stable(held);
	endproperty
	a_frozen_stable: assert property (p_frozen_stable)
		else $error("held pointers moved while frozen");

	property p_freeze_two;
		@(posedge clk) disable iff (reset)
		(ce && arm && dma && state == bpw_pkg::HOLD_TRACK) ##1 ce
		|=> frozen && held == $past(live);
	endproperty
	a_freeze_two: assert property (p_freeze_two)
		else $error("snapshot did not freeze two edges later");
endmodule

// ==== verification/ptr_source_model.sv ====
// behavioural pointer generator standing beyond the pointer window
`timescale 1ns/1ps
module ptr_source_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// bench control: free run or load fixed values
	input  wire logic        run,
	input  wire logic        load,
	input  wire logic [15:0] load_rd,
	input  wire logic [15:0] load_wr,
	input  wire logic [15:0] load_stop,
	// clear request from the block
	input  wire logic        ptr_clear,
	// live pointers
	output logic      [15:0] rd_ptr,
	output logic      [15:0] wr_ptr,
	output logic      [15:0] stop_ptr
);
	// clear wins over a load so a stale load cannot undo it
	always_ff @(posedge clk) begin
		if (reset || ptr_clear) begin
			rd_ptr   <= 16'h0000;
			wr_ptr   <= 16'h0000;
			stop_ptr <= 16'h0000;
		end else if (load) begin
			rd_ptr   <= load_rd;
			wr_ptr   <= load_wr;
			stop_ptr <= load_stop;
		end else if (run) begin
			// both bytes of the write pointer move, so a torn hold shows
			rd_ptr <= rd_ptr + 16'h0001;
			wr_ptr <= wr_ptr + 16'h0101;
		end
	end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the buffer pointer window
`timescale 1ns/1ps
module testbench;
	logic        clk, reset, psel, penable, pwrite, dma, run, load, e, ce;
	logic        pready, pslverr, rd_at, wr_at, ptr_clear;
	logic [11:0] paddr;
	logic [3:0]  pstrb;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] span_mask, rd_ptr, wr_ptr, stop_ptr, l_rd, l_wr, l_stop;
	int          failures, n_compared, clr_cnt;

	buffer_pointer_window buffer_pointer_window_inst (
		.CLK(clk), .RESET(reset), .CE(ce), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .RD_PTR(rd_ptr),
		.WR_PTR(wr_ptr), .STOP_PTR(stop_ptr), .DMA_ACTIVE(dma),
		.SPAN_MASK(span_mask), .RD_AT_STOP(rd_at),
		.WR_AT_STOP(wr_at), .PTR_CLEAR(ptr_clear));
	ptr_source_model ptr_source_model_inst (
		.clk(clk), .reset(reset), .run(run), .load(load),
		.load_rd(l_rd), .load_wr(l_wr), .load_stop(l_stop),
		.ptr_clear(ptr_clear), .rd_ptr(rd_ptr), .wr_ptr(wr_ptr),
		.stop_ptr(stop_ptr));

	// 25 MHz clock
	always #20 clk = ~clk;

	// count clear pulses as the edge samples them
	always @(posedge clk) begin
		if (ptr_clear === 1'b1) clr_cnt++;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] x, y);
		n_compared++;
		if (y !== x) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, x, y);
		end
	endtask

	// apb master; waits for pready, only the watchdog ends a dead wait
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'h1);
	endtask

	task automatic rdc(input string nm, input logic [11:0] a,
			input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		chk(nm, x, q);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_reset();
		chk("mask", 32'h0000_FFFF, {16'h0000, span_mask});
		rdc("status", 12'h180, 32'h0000_0004);
		rdc("span", 12'h150, 32'h0000_0000);
		rdc("hole", 12'h000, 32'h0000_0000);
		chk("hole err", 1'b1, e);
		rdc("odd", 12'h151, 32'h0000_0000);
		chk("odd err", 1'b1, e);
		$display("test reset done");
	endtask

	// each span: a bit just above it is ignored, its top bit is not
	task automatic test_span();
		logic [7:0] s;
		for (int k = 0; k <= 8; k++) begin
			s = 8'((16'h0001 << k) - 16'h0001);
			wr(12'h150, {24'h00_0000, s});
			repeat (3) @(posedge clk);
			chk("mask", {16'h0000, s, 8'hFF}, {16'h0000, span_mask});
			l_stop <= 16'hA5C3;
			l_rd <= 16'hA5C3 ^ (16'h0100 << k);
			l_wr <= 16'hA5C3 ^ (16'h0080 << k);
			load <= 1'b1;
			@(posedge clk);
			load <= 1'b0;
			repeat (3) @(posedge clk);
			chk("rd at stop", 1'b1, rd_at);
			chk("wr at stop", 1'b0, wr_at);
		end
		$display("test span done");
	endtask

	// pointers keep moving while the held copies are read
	task automatic test_snap();
		bpw_pkg::ptr_pair_t cap;
		dma <= 1'b1;
		run <= 1'b1;
		repeat (8) @(posedge clk);
		wr(12'h154, 32'h0000_0001);
		#1 cap = {rd_ptr, wr_ptr};
		repeat (4) @(posedge clk);
		rdc("frozen", 12'h180, 32'h0000_0007);
		rdc("rd lo", 12'h168, {24'h00_0000, cap.rd[7:0]});
		rdc("released", 12'h180, 32'h0000_0006);
		wr(12'h154, 32'h0000_0000);
		#1 cap = {rd_ptr, wr_ptr};
		repeat (5) @(posedge clk);
		rdc("wr hi", 12'h174, {24'h00_0000, cap.wr[15:8]});
		dma <= 1'b0;
		repeat (8) @(posedge clk);
		wr(12'h154, 32'h0000_0000);
		repeat (3) @(posedge clk);
		rdc("no dma", 12'h180, 32'h0000_0004);
		run <= 1'b0;
		$display("test snapshot done");
	endtask

	task automatic test_clear();
		int c0;
		c0 = clr_cnt;
		apb(1'b1, 12'h164, 32'h0000_00FF, 4'h0);
		repeat (3) @(posedge clk);
		chk("no strobe", c0, clr_cnt);
		wr(12'h164, 32'h0000_005A);
		repeat (3) @(posedge clk);
		chk("clear pulses", c0 + 1, clr_cnt);
		q = {16'h0000, rd_ptr | wr_ptr | stop_ptr};
		chk("pointers", 32'h0000_0000, q);
		$display("test clear done");
	endtask

	// with the clock enable low the stop compare must not move
	task automatic test_ce();
		ce <= 1'b0;
		l_rd <= 16'h0000;
		l_wr <= 16'h0001;
		l_stop <= 16'h0000;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		repeat (3) @(posedge clk);
		chk("ce low", 1'b1, wr_at);
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		chk("ce high", 1'b0, wr_at);
		$display("test ce done");
	endtask

	task automatic end_sim();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		ce = 1'b1;
		{psel, penable, pwrite, dma, run, load} = 6'h00;
		paddr = 12'h000;
		pstrb = 4'h0;
		pwdata = 32'h0000_0000;
		{l_rd, l_wr, l_stop} = 48'h0000_0000_0000;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		test_reset();
		test_span();
		test_snap();
		test_clear();
		test_ce();
		end_sim();
	end

	// the tests need well under a thousand cycles; this is ample margin
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		end_sim();
	end
endmodule
